// [src/bdc_pkg.sv]
// Package with constants and types for the bus driver digital control.
package bdc_pkg;
    // Mode filter time and its cycle count at 20 MHz (least time, rounded up).
    localparam int unsigned FILTER_TIME_NS  = 1000;
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned FILTER_CYCLES   = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GOTO_SLEEP_NS   = 1000;
    localparam int unsigned GOTO_SLEEP_CYC  = (GOTO_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES     = 2;

    // Levels that unconnected inputs float to.
    localparam logic DEF_TXD   = 1'b0;
    localparam logic DEF_TXG_N = 1'b1;
    localparam logic DEF_STB_N = 1'b0;
    localparam logic DEF_MODE  = 1'b0;
    localparam logic DEF_GUARD = 1'b0;

    typedef enum logic [2:0] {
        NORMAL_STATE,
        RECEIVE_ONLY_STATE,
        STANDBY_STATE,
        GOTO_SLEEP_CMD,
        SLEEP_STATE
    } bdc_mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_LOW_SYMBOL,
        BUS_HIGH_SYMBOL
    } bdc_sym_t;

    typedef enum logic [1:0] {
        BIAS_OPEN,
        BIAS_GROUND,
        BIAS_VOLTAGE
    } bdc_bias_t;
endpackage

// [src/bdc_sync.sv]
// Two-stage synchroniser for a vector of asynchronous pin levels.
`timescale 1ns/10ps
module bdc_sync
    import bdc_pkg::*;
#(
    parameter int unsigned WIDTH     = 8,
    parameter logic [WIDTH-1:0] INIT = '0
)(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] hold_reg;

    initial
    begin
        if (WIDTH < 1) $error("bdc_sync: WIDTH must be at least 1.");
    end

    // The first stage is read only by the second stage.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= INIT;
            hold_reg <= INIT;
        end
        else
        begin
            meta_reg <= async_in;
            hold_reg <= meta_reg;
        end
    end

    assign sync_out = hold_reg;
endmodule

// [src/bdc_filter.sv]
// Persistence filter that passes a level only after it stays stable.
`timescale 1ns/10ps
module bdc_filter
    import bdc_pkg::*;
#(
    parameter int unsigned WIDTH  = 2,
    parameter int unsigned CYCLES = FILTER_CYCLES,
    parameter logic [WIDTH-1:0] INIT = '0
)(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] filt_out
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [WIDTH-1:0] filt_reg;
    logic [WIDTH-1:0] cand_reg;
    logic [CW-1:0]    cnt_reg;
    logic [CW-1:0]    cnt_next;
    wire              changed = (raw_in != cand_reg);
    wire              settled = (cnt_reg == CW'(CYCLES - 1));

    initial
    begin
        if (CYCLES < 1) $error("bdc_filter: CYCLES must be at least 1.");
    end

    // The whole vector must be stable together, so a skew between pins restarts the count.
    assign cnt_next = changed ? '0 : (settled ? cnt_reg : cnt_reg + CW'(1));

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            filt_reg <= INIT;
            cand_reg <= INIT;
            cnt_reg  <= '0;
        end
        else
        begin
            cand_reg <= raw_in;
            cnt_reg  <= cnt_next;
            if (!changed && settled)
                filt_reg <= cand_reg;
        end
    end

    assign filt_out = filt_reg;
endmodule

// [src/bdc_top.sv]
// Digital control of a differential bus transceiver: modes, transmit gating, receive outputs.
// Behaviour
// - Floating transmit gate or guardian disables transmitter.
// - Floating transmit data drives low symbol.
// - Floating mode pins decode standby state.
// - Unconnected inputs take their pull default levels.
// - Low power and receive only ignore transmit inputs.
// - Transmitter active only in normal state.
// - Bus biasing selected per operating mode.
// - Reference fail forces receive data low.
// - Enable needs normal, gate low, guardian high.
// - Gate activation accepted only with data low.
// - Enabled transmitter follows transmit data stream.
// - Receive data shows bus symbol when active.
// - Receive data shows wake flag in low power.
// - Reference fail forces activity low, guardian default.
// - Guardian low blocks transmitter in normal state.
// - Activity output low when symbol present in normal or receive only state.
// - Activity output shows wake flag in low power.
// - Reference fail forces fault low, mode defaults.
// - Mode pins select mode by table.
// - Mode pins pass spike filter before decoding.
// - Wake detector stays active in every mode.
// - Any undervoltage signalled on fault output.
// - Short mode pulses leave mode unchanged.
`timescale 1ns/10ps
module bdc_top
    import bdc_pkg::*;
#(
    parameter int unsigned FILTER_CNT = FILTER_CYCLES,
    parameter int unsigned SLEEP_CNT  = GOTO_SLEEP_CYC
)(
    input  wire logic  clk,
    input  wire logic  sys_rst,
    input  wire logic  transmit_data_in,
    input  wire logic  transmit_data_open,
    input  wire logic  transmit_gate_n,
    input  wire logic  transmit_gate_open,
    input  wire logic  guardian_gate,
    input  wire logic  guardian_gate_open,
    input  wire logic  standby_select_n,
    input  wire logic  standby_select_open,
    input  wire logic  mode_select_primary,
    input  wire logic  mode_select_open,
    input  wire logic  io_ref_fail,
    input  wire logic  supply_fail,
    input  wire logic  wake_event,
    input  wire logic  wake_clear,
    input  wire logic  bus_rx_active,
    input  wire logic  bus_rx_high,
    output logic       receive_data_out,
    output logic       bus_activity_n,
    output logic       fault_indicator_n,
    output logic       pulls_enable,
    output bdc_sym_t   tx_symbol,
    output bdc_bias_t  bias_select,
    output bdc_mode_t  mode_out
);
    localparam int unsigned NIN = 13;
    localparam int unsigned SCW = $clog2(SLEEP_CNT + 1);
    // All levels of the main synchroniser reset low, so no false reference failure follows reset.
    localparam logic [NIN-1:0] SYNC_INIT = '0;

    initial
    begin
        if (SLEEP_CNT < 1) $error("bdc_top: SLEEP_CNT must be at least 1.");
    end

    logic [NIN-1:0] s;
    bdc_sync #(.WIDTH(NIN), .INIT(SYNC_INIT)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({bus_rx_active, bus_rx_high, wake_clear, wake_event, supply_fail, io_ref_fail,
                    mode_select_open, mode_select_primary, standby_select_open, standby_select_n,
                    guardian_gate_open, guardian_gate, transmit_gate_open}),
        .sync_out (s)
    );

    // The controller pins have their own synchroniser; the gate resets to its blocking level.
    logic [2:0] t;
    bdc_sync #(.WIDTH(3), .INIT(3'b001)) u_sync_tx (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({transmit_data_open, transmit_data_in, transmit_gate_n}),
        .sync_out (t)
    );

    wire s_gate_open = s[0];
    wire s_guard     = s[1];
    wire s_guard_opn = s[2];
    wire s_stb_n     = s[3];
    wire s_stb_open  = s[4];
    wire s_mode      = s[5];
    wire s_mode_open = s[6];
    wire s_ioref     = s[7];
    wire s_supply    = s[8];
    wire s_wake      = s[9];
    wire s_wclr      = s[10];
    wire s_rx_high   = s[11];
    wire s_rx_act    = s[12];
    wire s_gate_n    = t[0];
    wire s_txd       = t[1];
    wire s_txd_open  = t[2];

    // Floating pins read as their pull levels.
    wire stb_lvl  = s_stb_open  ? DEF_STB_N : s_stb_n;
    wire mode_lvl = s_mode_open ? DEF_MODE  : s_mode;

    // Reference failure forces mode pins to defaults.
    wire stb_eff  = s_ioref ? DEF_STB_N : stb_lvl;
    wire mode_eff = s_ioref ? DEF_MODE  : mode_lvl;

    // Spike filter in front of decoding.
    logic [1:0] mode_f;
    bdc_filter #(.WIDTH(2), .CYCLES(FILTER_CNT), .INIT(2'b00)) u_filt (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .raw_in   ({stb_eff, mode_eff}),
        .filt_out (mode_f)
    );

    // Wake flag is captured in every mode; a new event wins over a clear.
    logic wake_flag_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wake_flag_reg <= 1'b0;
        else if (s_wake)
            wake_flag_reg <= 1'b1;
        else if (s_wclr)
            wake_flag_reg <= 1'b0;
    end

    // Mode table decode; low/low gives standby.
    bdc_mode_t req_mode;
    assign req_mode = ( mode_f[1] &&  mode_f[0]) ? NORMAL_STATE :
                      ( mode_f[1] && !mode_f[0]) ? RECEIVE_ONLY_STATE :
                      (!mode_f[1] &&  mode_f[0]) ? GOTO_SLEEP_CMD : STANDBY_STATE;

    bdc_mode_t  mode_reg;
    bdc_mode_t  mode_next;
    logic [SCW-1:0] gts_cnt_reg;
    wire        gts_done = (gts_cnt_reg == SCW'(SLEEP_CNT - 1));

    // Only the filtered level and the goto-sleep timer move the mode; the reference failure forces sleep.
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            GOTO_SLEEP_CMD:
                if (req_mode != GOTO_SLEEP_CMD)
                    mode_next = req_mode;
                else if (gts_done)
                    mode_next = SLEEP_STATE;
            SLEEP_STATE:
                if (req_mode != GOTO_SLEEP_CMD && !s_ioref)
                    mode_next = req_mode;
            default:
                mode_next = req_mode;
        endcase
        if (s_ioref)
            mode_next = SLEEP_STATE;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mode_reg    <= STANDBY_STATE;
            gts_cnt_reg <= '0;
        end
        else
        begin
            mode_reg    <= mode_next;
            gts_cnt_reg <= (mode_reg == GOTO_SLEEP_CMD && !gts_done) ? gts_cnt_reg + SCW'(1) : '0;
        end
    end

    wire is_normal = (mode_reg == NORMAL_STATE);
    wire low_power = (mode_reg == SLEEP_STATE) || (mode_reg == STANDBY_STATE);
    wire rx_mode   = is_normal || (mode_reg == RECEIVE_ONLY_STATE);

    // Floating gate pins read as blocking levels; on reference fail too.
    wire gate_n_eff = (s_gate_open  || s_ioref) ? DEF_TXG_N : s_gate_n;
    wire guard_eff  = (s_guard_opn  || s_ioref) ? DEF_GUARD : s_guard;
    wire txd_eff    = (s_txd_open   || s_ioref) ? DEF_TXD   : s_txd;

    // Outside normal state the transmit inputs are ignored and pulls are off.
    wire tx_inputs_live = is_normal;
    wire tx_allowed = tx_inputs_live && !gate_n_eff && guard_eff;

    // Activation is accepted only while the data is low.
    logic tx_on_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            tx_on_reg <= 1'b0;
        else if (!tx_allowed)
            tx_on_reg <= 1'b0;
        else if (!txd_eff)
            tx_on_reg <= 1'b1;
    end

    // Enabled transmitter follows the data stream.
    bdc_sym_t sym_next;
    assign sym_next = !(tx_allowed && (tx_on_reg || !txd_eff)) ? BUS_IDLE :
                      (txd_eff ? BUS_HIGH_SYMBOL : BUS_LOW_SYMBOL);

    // Bias per mode; open while unsupplied.
    bdc_bias_t bias_next;
    assign bias_next = s_supply ? BIAS_OPEN : (rx_mode ? BIAS_VOLTAGE : BIAS_GROUND);

    wire rxd_next = s_ioref   ? 1'b0 :
                    low_power ? !wake_flag_reg :
                    rx_mode   ? (!s_rx_act || s_rx_high) : 1'b1;
    wire act_next = s_ioref   ? 1'b0 :
                    low_power ? !wake_flag_reg :
                    rx_mode   ? !s_rx_act : 1'b1;
    // Any undervoltage pulls the fault output low.
    wire flt_next = !(s_ioref || s_supply);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_symbol         <= BUS_IDLE;
            bias_select       <= BIAS_GROUND;
            receive_data_out  <= 1'b1;
            bus_activity_n    <= 1'b1;
            fault_indicator_n <= 1'b1;
            pulls_enable      <= 1'b0;
        end
        else
        begin
            tx_symbol         <= sym_next;
            bias_select       <= bias_next;
            receive_data_out  <= rxd_next;
            bus_activity_n    <= act_next;
            fault_indicator_n <= flt_next;
            pulls_enable      <= tx_inputs_live;
        end
    end

    assign mode_out = mode_reg;

    a_tx_mode_only: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_symbol != BUS_IDLE) |-> $past(is_normal)) else $error("Transmit outside normal state.");
    a_guard_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        !guard_eff |=> (tx_symbol == BUS_IDLE)) else $error("Guardian low did not block.");
    // Gate high keeps the bus idle.
    a_gate_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        gate_n_eff |=> (tx_symbol == BUS_IDLE)) else $error("Gate high did not block.");
    // No start with a high symbol.
    a_no_high_start: assert property (@(posedge clk) disable iff (sys_rst)
        ($past(tx_symbol) == BUS_IDLE) |-> (tx_symbol != BUS_HIGH_SYMBOL)) else $error("Started with high.");
    a_tx_follow: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_allowed && tx_on_reg) |=> (tx_symbol == (($past(txd_eff)) ? BUS_HIGH_SYMBOL : BUS_LOW_SYMBOL)))
        else $error("Symbol did not follow data.");
    a_ref_rxd: assert property (@(posedge clk) disable iff (sys_rst)
        s_ioref |=> (!receive_data_out && !bus_activity_n && !fault_indicator_n))
        else $error("Reference failure outputs wrong.");
    // Wake flag shown in low power.
    a_wake_show: assert property (@(posedge clk) disable iff (sys_rst)
        (low_power && !s_ioref) |=> (receive_data_out == !$past(wake_flag_reg)))
        else $error("Wake flag not shown.");
    a_act_bus: assert property (@(posedge clk) disable iff (sys_rst)
        (rx_mode && !s_ioref) |=> (bus_activity_n == !$past(s_rx_act))) else $error("Activity wrong.");
    a_bias_mode: assert property (@(posedge clk) disable iff (sys_rst)
        (rx_mode && !s_supply) |=> (bias_select == BIAS_VOLTAGE)) else $error("Bias wrong.");
    // Mode stable while filter output holds, outside goto-sleep, sleep and reference failure.
    a_mode_hold: assert property (@(posedge clk) disable iff (sys_rst)
        ($stable(mode_f) && !s_ioref && mode_reg != GOTO_SLEEP_CMD && mode_reg != SLEEP_STATE)
        |=> $stable(mode_reg)) else $error("Mode moved without command.");
    a_goto_ground: assert property (@(posedge clk) disable iff (sys_rst)
        (mode_reg == GOTO_SLEEP_CMD && !s_supply) |=> (bias_select == BIAS_GROUND))
        else $error("Bias not ground in sleep command.");
    a_pulls_normal: assert property (@(posedge clk) disable iff (sys_rst)
        !is_normal |=> !pulls_enable) else $error("Pulls on outside normal state.");
    a_fault_supply: assert property (@(posedge clk) disable iff (sys_rst)
        s_supply |=> !fault_indicator_n) else $error("Supply failure not flagged.");
    a_wake_set: assert property (@(posedge clk) disable iff (sys_rst)
        s_wake |=> wake_flag_reg) else $error("Wake event lost.");
    a_rx_low: assert property (@(posedge clk) disable iff (sys_rst)
        (rx_mode && !s_ioref && s_rx_act && !s_rx_high) |=> !receive_data_out)
        else $error("Low symbol not received.");

    c_transmit: cover property (@(posedge clk) tx_symbol == BUS_HIGH_SYMBOL);
    c_sleep:    cover property (@(posedge clk) mode_reg == SLEEP_STATE);
    c_recv:     cover property (@(posedge clk) mode_reg == RECEIVE_ONLY_STATE && !bus_activity_n);
    c_wake:     cover property (@(posedge clk) low_power && !receive_data_out);
    c_goto:     cover property (@(posedge clk) mode_reg == GOTO_SLEEP_CMD);
endmodule

// [verif/bdc_bus_model.sv]
// Bus model: echoes our own symbol and lets the bench inject traffic of another node.
`timescale 1ns/10ps
module bdc_bus_model
    import bdc_pkg::*;
(
    input  wire logic     clk,
    input  wire bdc_sym_t tx_symbol,
    input  wire bdc_sym_t ext_symbol,
    output logic          bus_rx_active,
    output logic          bus_rx_high
);
    logic toggle_reg = 1'h0;
    wire  tx_on      = (tx_symbol != BUS_IDLE);
    wire  ext_on     = (ext_symbol != BUS_IDLE);
    wire  ext_high   = (ext_symbol == BUS_HIGH_SYMBOL);

    // An idle bus has no polarity, so the high flag wanders to expose a receiver that trusts it.
    always_ff @(posedge clk)
    begin
        toggle_reg <= ~toggle_reg;
    end

    assign bus_rx_active = tx_on | ext_on;
    assign bus_rx_high   = tx_on ? (tx_symbol == BUS_HIGH_SYMBOL) : (ext_on ? ext_high : toggle_reg);
endmodule

// [verif/bdc_top_tb.sv]
// Self-checking bench for the bus driver digital control.
`timescale 1ns/10ps
module bdc_top_tb;
    import bdc_pkg::*;
    localparam int unsigned LAT = 4;
    logic      clk = 1'h0;
    logic      sys_rst = 1'h1;
    logic      txd = 1'h0;
    logic      txd_open = 1'h0;
    logic      txg_n = 1'h1;
    logic      txg_open = 1'h0;
    logic      grd = 1'h0;
    logic      grd_open = 1'h0;
    logic      stb_n = 1'h0;
    logic      stb_open = 1'h0;
    logic      msel = 1'h0;
    logic      msel_open = 1'h0;
    logic      io_fail = 1'h0;
    logic      sup_fail = 1'h0;
    logic      wake_ev = 1'h0;
    logic      wake_clr = 1'h0;
    logic      rx_act;
    logic      rx_high;
    logic      rxd;
    logic      act_n;
    logic      flt_n;
    logic      pulls;
    bdc_sym_t  tx_sym;
    bdc_sym_t  ext_sym = BUS_IDLE;
    bdc_bias_t bias;
    bdc_mode_t mode;
    int        miscompares = 0;
    int        n_compared = 0;

    always #25 clk = ~clk;

    bdc_top #(.FILTER_CNT(2), .SLEEP_CNT(2)) u_bdc_top (
        .clk                 (clk),
        .sys_rst             (sys_rst),
        .transmit_data_in    (txd),
        .transmit_data_open  (txd_open),
        .transmit_gate_n     (txg_n),
        .transmit_gate_open  (txg_open),
        .guardian_gate       (grd),
        .guardian_gate_open  (grd_open),
        .standby_select_n    (stb_n),
        .standby_select_open (stb_open),
        .mode_select_primary (msel),
        .mode_select_open    (msel_open),
        .io_ref_fail         (io_fail),
        .supply_fail         (sup_fail),
        .wake_event          (wake_ev),
        .wake_clear          (wake_clr),
        .bus_rx_active       (rx_act),
        .bus_rx_high         (rx_high),
        .receive_data_out    (rxd),
        .bus_activity_n      (act_n),
        .fault_indicator_n   (flt_n),
        .pulls_enable        (pulls),
        .tx_symbol           (tx_sym),
        .bias_select         (bias),
        .mode_out            (mode)
    );

    bdc_bus_model u_bdc_bus_model (
        .clk           (clk),
        .tx_symbol     (tx_sym),
        .ext_symbol    (ext_sym),
        .bus_rx_active (rx_act),
        .bus_rx_high   (rx_high)
    );

    task automatic print_verdict();
        if (miscompares == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Sampling on the falling edge keeps checks clear of the launching edge.
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_mode(input bdc_mode_t m);
        for (int i = 0; i < 80 && mode !== m; i++)
            @(negedge clk);
        // A mode that never arrives counts a mismatch here and the run goes on to the verdict.
        check(mode, m);
        cyc(2);
    endtask

    task automatic tx_step(input logic d, dop, g, gop, b, bop, input bdc_sym_t exp);
        @(posedge clk);
        txd <= d;
        txd_open <= dop;
        txg_n <= g;
        txg_open <= gop;
        grd <= b;
        grd_open <= bop;
        cyc(LAT);
        check(tx_sym, exp);
    endtask

    task automatic rx_step(input bdc_sym_t s, input logic rd, input logic an);
        @(posedge clk);
        ext_sym <= s;
        cyc(LAT);
        check(rxd, rd);
        check(act_n, an);
    endtask

    task automatic set_pins(input logic s, input logic m);
        @(posedge clk);
        stb_n <= s;
        msel <= m;
    endtask

    task automatic pulse_wake(input logic clr);
        @(posedge clk);
        if (clr)
            wake_clr <= 1'h1;
        else
            wake_ev <= 1'h1;
        @(posedge clk);
        wake_clr <= 1'h0;
        wake_ev <= 1'h0;
    endtask

    task automatic t_reset();
        check(mode, STANDBY_STATE);
        check(bias, BIAS_GROUND);
        check({rxd, act_n, flt_n}, 3'h7);
        check({pulls, tx_sym}, 3'h0);
        @(posedge clk);
        {txd_open, txg_open, grd_open, stb_open, msel_open} <= 5'h1F;
        {txd, txg_n, grd, stb_n, msel} <= 5'h17;
        cyc(30);
        check(mode, STANDBY_STATE);
        check(tx_sym, BUS_IDLE);
        @(posedge clk);
        {txd_open, txg_open, grd_open, stb_open, msel_open} <= 5'h00;
    endtask

    task automatic t_modes();
        logic [1:0] pins [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
        bdc_mode_t  m    [4] = '{RECEIVE_ONLY_STATE, STANDBY_STATE, SLEEP_STATE, NORMAL_STATE};
        bdc_bias_t  bs   [4] = '{BIAS_VOLTAGE, BIAS_GROUND, BIAS_GROUND, BIAS_VOLTAGE};
        for (int i = 0; i < 4; i++)
        begin
            // Host holds each command far longer than the filter time.
            set_pins(pins[i][1], pins[i][0]);
            wait_mode(m[i]);
            check(bias, bs[i]);
            check(pulls, i == 3);
        end
    endtask

    task automatic t_transmit();
        tx_step(1, 0, 0, 0, 1, 0, BUS_IDLE);
        tx_step(0, 0, 0, 0, 1, 0, BUS_LOW_SYMBOL);
        // The echo runs the receive path too, so it settles later than the symbol.
        cyc(LAT);
        check({rxd, act_n}, 2'h0);
        tx_step(1, 0, 0, 0, 1, 0, BUS_HIGH_SYMBOL);
        cyc(LAT);
        check({rxd, act_n}, 2'h2);
        tx_step(1, 0, 0, 0, 0, 0, BUS_IDLE);
        tx_step(0, 0, 0, 0, 1, 0, BUS_LOW_SYMBOL);
        tx_step(0, 0, 0, 0, 1, 1, BUS_IDLE);
        tx_step(0, 0, 0, 1, 1, 0, BUS_IDLE);
        tx_step(0, 0, 0, 0, 1, 0, BUS_LOW_SYMBOL);
        tx_step(1, 1, 0, 0, 1, 0, BUS_LOW_SYMBOL);
        tx_step(0, 0, 1, 0, 1, 0, BUS_IDLE);
        cyc(LAT);
        check({rxd, act_n}, 2'h3);
        // Controller keeps data low while opening the gate.
        tx_step(0, 0, 0, 0, 1, 0, BUS_LOW_SYMBOL);
    endtask

    task automatic t_receive();
        set_pins(1, 0);
        wait_mode(RECEIVE_ONLY_STATE);
        check(tx_sym, BUS_IDLE);
        rx_step(BUS_LOW_SYMBOL, 0, 0);
        rx_step(BUS_HIGH_SYMBOL, 1, 0);
        rx_step(BUS_IDLE, 1, 1);
        @(posedge clk);
        msel <= 1'h1;
        @(posedge clk);
        msel <= 1'h0;
        cyc(12);
        check(mode, RECEIVE_ONLY_STATE);
    endtask

    task automatic t_wake();
        set_pins(0, 0);
        pulse_wake(0);
        wait_mode(STANDBY_STATE);
        cyc(LAT);
        check({rxd, act_n}, 2'h0);
        pulse_wake(1);
        rx_step(BUS_LOW_SYMBOL, 1, 1);
        pulse_wake(0);
        cyc(LAT);
        check({rxd, act_n}, 2'h0);
        pulse_wake(1);
        rx_step(BUS_IDLE, 1, 1);
    endtask

    task automatic t_supply();
        set_pins(1, 1);
        wait_mode(NORMAL_STATE);
        check(tx_sym, BUS_LOW_SYMBOL);
        @(posedge clk);
        io_fail <= 1'h1;
        wait_mode(SLEEP_STATE);
        check(rxd, 0);
        check(act_n, 0);
        check(flt_n, 0);
        check(tx_sym, BUS_IDLE);
        @(posedge clk);
        io_fail <= 1'h0;
        wait_mode(NORMAL_STATE);
        check(flt_n, 1);
        @(posedge clk);
        sup_fail <= 1'h1;
        cyc(LAT);
        check(flt_n, 0);
        check(bias, BIAS_OPEN);
        @(posedge clk);
        sup_fail <= 1'h0;
        cyc(LAT);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        cyc(2);
        t_reset();
        t_modes();
        t_transmit();
        t_receive();
        t_wake();
        t_supply();
        print_verdict();
    end
endmodule
